// >>> hdl/ddp_pkg.sv
// ddp_pkg: constants, timing counts and state codes for both link ends.
// assumes a single 20 MHz clock shared by both ends.
package ddp_pkg;
	localparam int CLK_MHZ = 20;
	localparam int NOUT = 11;
	localparam int NHB = 6;
	localparam int CNT_W = 15;
	localparam int SEL_W = 4;
	// times as printed, in ns; cycle counts round minimum times upward
	localparam int WAKE_WAIT_NS = 10000;
	localparam int WIN_NS = 256000;
	localparam int DIAG_NS = 32000;
	localparam int OL_NS = 1000000;
	localparam int OC_NS = 55000;
	localparam int BLANK_NS = 64000;
	localparam int TD_ON_NS = 8000;
	localparam int TD_OFF_NS = 8000;
	localparam int MINOFF_NS = WIN_NS - TD_ON_NS - TD_OFF_NS;
	localparam int XC_NS = 1000;
	localparam int REC_NS = 500000;
	localparam int CSN_HI_NS = 4000;
	localparam int WAKE_WAIT_CYC = (WAKE_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int WIN_CYC = (WIN_NS * CLK_MHZ + 999) / 1000;
	localparam int DIAG_CYC = (DIAG_NS * CLK_MHZ + 999) / 1000;
	localparam int OL_CYC = (OL_NS * CLK_MHZ + 999) / 1000;
	localparam int OC_CYC = (OC_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int MINOFF_CYC = (MINOFF_NS * CLK_MHZ + 999) / 1000;
	localparam int XC_CYC = (XC_NS * CLK_MHZ + 999) / 1000;
	localparam int REC_CYC = (REC_NS * CLK_MHZ + 999) / 1000;
	localparam int CSN_HI_CYC = (CSN_HI_NS * CLK_MHZ + 999) / 1000;
	// outputs 5, 8 and 10 gate from the shared pin, the rest from input a
	localparam logic [NOUT-1:0] PWM2_MASK = 11'h290;
	localparam logic [SEL_W-1:0] CM_NONE = 4'h0;
	// global diagnostic slots
	localparam int G_OV = 0;
	localparam int G_UV = 1;
	localparam int G_TW = 2;
	localparam int G_TSD = 3;
	localparam logic GUARD_RST = 1'b1;
	typedef enum logic [3:0] {
		ST_STBY = 4'b0001,
		ST_WAKE = 4'b0010,
		ST_ARM = 4'b0100,
		ST_RUN = 4'b1000
	} ddp_state_e;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_SEL = 3'b010,
		HS_REL = 3'b100
	} ddp_host_e;
endpackage

// >>> hdl/ddp_link_if.sv
// ddp_link_if: parallel link between controller end and driver end.
// assumes both ends run on the same clock; no clocking block here.
`timescale 1ns/100ps
interface ddp_link_if;
	import ddp_pkg::*;
	logic chip_select_low;
	logic enable_hold;
	logic [NOUT-1:0] hs_ctrl;
	logic [NHB-1:0] ls_ctrl;
	logic [NOUT-1:0] pwm_en;
	logic [NOUT-1:0] oc_recov;
	logic sup_recov_dis;
	logic low_bat_guard;
	logic [SEL_W-1:0] cm_sel;
	logic [NOUT-1:0] clr_oc;
	logic [NOUT-1:0] clr_ol;
	logic clr_sup;
	logic clr_temp;
	logic [NOUT-1:0] oc_flag;
	logic [NOUT-1:0] ol_flag;
	logic [3:0] glb_flag;
	logic dev_awake;
	modport dev (
		input chip_select_low, enable_hold, hs_ctrl, ls_ctrl, pwm_en,
		input oc_recov, sup_recov_dis, low_bat_guard, cm_sel,
		input clr_oc, clr_ol, clr_sup, clr_temp,
		output oc_flag, ol_flag, glb_flag, dev_awake
	);
	modport mcu (
		output chip_select_low, enable_hold, hs_ctrl, ls_ctrl, pwm_en,
		output oc_recov, sup_recov_dis, low_bat_guard, cm_sel,
		output clr_oc, clr_ol, clr_sup, clr_temp,
		input oc_flag, ol_flag, glb_flag, dev_awake
	);
endinterface

// >>> hdl/ddp_dev_end.sv
// ddp_dev_end: driver-side sequencing, diagnostics and output gating.
// assumes analog detector levels arrive synchronous to clk_in.
`timescale 1ns/100ps
module ddp_dev_end import ddp_pkg::*; #(
	parameter int P_WIN_CYC = WIN_CYC,
	parameter int P_OL_CYC = OL_CYC,
	parameter int P_MINOFF_CYC = MINOFF_CYC,
	parameter int P_REC_CYC = REC_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	ddp_link_if.dev lnk,
	input wire logic vcc_low_in,
	input wire logic [NOUT-1:0] oc_det_in,
	input wire logic [NOUT-1:0] ul_det_in,
	input wire logic vs_ov_in,
	input wire logic vs_uv_in,
	input wire logic temp_warning_in,
	input wire logic thermal_shutdown_in,
	input wire logic pwm_input_a_in,
	input wire logic shared_monitor_pwm_pin_in,
	output logic shared_monitor_pwm_pin_out,
	output logic shared_monitor_pwm_pin_oe_n_out,
	output logic current_monitor_out,
	output logic [NOUT-1:0] power_output_n_out,
	output logic [NHB-1:0] ls_drv_out,
	output logic [NHB-1:0] fast_off_out,
	output logic outputs_hiz_out,
	output logic ec_hiz_out
);
	ddp_state_e state_r;
	logic [CNT_W-1:0] seq_cnt_r;
	logic wipe;
	logic run;
	logic block_all;
	logic sup_block;
	logic pwm_b;
	logic [3:0] g_cond;
	logic [3:0] g_hit;
	logic [3:0] g_ok;
	logic [3:0] g_clr;
	logic [3:0] g_flag_r;
	logic [NOUT-1:0] hs_r;
	logic [NOUT-1:0] hs_nxt;
	logic [NHB-1:0] ls_r;
	logic [NOUT-1:0] oc_flag_r;
	logic [NOUT-1:0] ol_flag_r;
	logic awake_r;
	logic hiz_r;
	logic ec_hiz_r;
	logic [SEL_W-1:0] cm_prev_r;
	logic [CNT_W-1:0] blank_cnt_r;
	logic cm_valid_r;
	logic pin_oe_n_r;
	logic cm_on;
	logic [SEL_W-1:0] cm_idx;

	// wake, keep-alive window and delayed driver enable
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= ST_STBY;
			seq_cnt_r <= '0;
		end else if (vcc_low_in) begin
			state_r <= ST_STBY;
			seq_cnt_r <= '0;
		end else begin
			case (state_r)
				ST_STBY: begin
					seq_cnt_r <= '0;
					if (!lnk.chip_select_low) begin
						state_r <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (lnk.enable_hold) begin
						state_r <= ST_ARM;
						seq_cnt_r <= '0;
					end else if (seq_cnt_r == CNT_W'(P_WIN_CYC - 1)) begin
						state_r <= ST_STBY;
					end else begin
						seq_cnt_r <= seq_cnt_r + 1'b1;
					end
				end
				ST_ARM: begin
					if (!lnk.enable_hold) begin
						state_r <= ST_STBY;
					end else if (!lnk.chip_select_low) begin
						seq_cnt_r <= '0;
					end else if (seq_cnt_r == CNT_W'(P_WIN_CYC - 1)) begin
						state_r <= ST_RUN;
					end else begin
						seq_cnt_r <= seq_cnt_r + 1'b1;
					end
				end
				ST_RUN: begin
					if (!lnk.enable_hold) begin
						state_r <= ST_STBY;
					end
				end
				default: state_r <= ST_STBY;
			endcase
		end
	end

	// window expiry and logic-supply loss both wipe latched state
	assign wipe = vcc_low_in | (state_r == ST_WAKE && !lnk.enable_hold
		&& seq_cnt_r == CNT_W'(P_WIN_CYC - 1));
	assign run = (state_r == ST_RUN);
	// low-battery guard keeps an undervoltage trip latched, so a short
	// to ground cannot make the supply bounce the drivers on and off
	assign sup_block = g_ok[G_OV] | g_ok[G_UV]
		| ((lnk.sup_recov_dis | lnk.low_bat_guard) & g_flag_r[G_UV])
		| (lnk.sup_recov_dis & g_flag_r[G_OV]);
	assign block_all = !run | sup_block | g_flag_r[G_TSD];
	assign g_cond = {thermal_shutdown_in, temp_warning_in, vs_uv_in,
		vs_ov_in};
	// temperature flags only clear once the condition has gone
	assign g_clr = {lnk.clr_temp & !g_cond[G_TSD],
		lnk.clr_temp & !g_cond[G_TW], lnk.clr_sup, lnk.clr_sup};
	// shared pin is an input whenever no output is selected or the device is not running
	assign pwm_b = pin_oe_n_r ? shared_monitor_pwm_pin_in : 1'b0;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_glb
			logic [CNT_W-1:0] cnt_r;
			assign g_hit[g] = g_cond[g] && cnt_r == CNT_W'(DIAG_CYC - 1);
			assign g_ok[g] = (cnt_r == CNT_W'(DIAG_CYC));
			// filter: condition must hold without a gap
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					cnt_r <= '0;
				end else if (!g_cond[g] || wipe) begin
					cnt_r <= '0;
				end else if (cnt_r != CNT_W'(DIAG_CYC)) begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
			// sticky flag; a new hit beats a clear in the same cycle
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					g_flag_r[g] <= 1'b0;
				end else if (wipe) begin
					g_flag_r[g] <= 1'b0;
				end else if (g_hit[g]) begin
					g_flag_r[g] <= 1'b1;
				end else if (g_clr[g]) begin
					g_flag_r[g] <= 1'b0;
				end
			end
		end

		for (g = 0; g < NOUT; g++) begin : g_out
			logic [CNT_W-1:0] oc_cnt_r;
			logic [CNT_W-1:0] ol_cnt_r;
			logic [CNT_W-1:0] rec_cnt_r;
			logic [CNT_W-1:0] mo_cnt_r;
			logic oc_off_r;
			logic oc_hit;
			logic ol_hit;
			logic act;
			logic want;
			logic src;
			assign act = hs_r[g] | (g < NHB ? ls_r[g % NHB] : 1'b0);
			assign oc_hit = oc_det_in[g] && oc_cnt_r == CNT_W'(OC_CYC - 1);
			assign ol_hit = act && ul_det_in[g]
				&& ol_cnt_r == CNT_W'(P_OL_CYC - 1);
			assign src = PWM2_MASK[g] ? pwm_b : pwm_input_a_in;
			// under-current and warning are absent here by design
			assign want = (lnk.pwm_en[g] ? src & lnk.hs_ctrl[g]
				: lnk.hs_ctrl[g])
				& !oc_off_r & !block_all & mo_cnt_r == '0;
			// diagnostic filters
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					oc_cnt_r <= '0;
					ol_cnt_r <= '0;
				end else begin
					if (!oc_det_in[g] || wipe) begin
						oc_cnt_r <= '0;
					end else if (oc_cnt_r != CNT_W'(OC_CYC)) begin
						oc_cnt_r <= oc_cnt_r + 1'b1;
					end
					if (!(act && ul_det_in[g]) || wipe) begin
						ol_cnt_r <= '0;
					end else if (ol_cnt_r != CNT_W'(P_OL_CYC)) begin
						ol_cnt_r <= ol_cnt_r + 1'b1;
					end
				end
			end
			// status flags, set wins over clear
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					oc_flag_r[g] <= 1'b0;
					ol_flag_r[g] <= 1'b0;
				end else if (wipe) begin
					oc_flag_r[g] <= 1'b0;
					ol_flag_r[g] <= 1'b0;
				end else begin
					if (oc_hit) begin
						oc_flag_r[g] <= 1'b1;
					end else if (lnk.clr_oc[g]) begin
						oc_flag_r[g] <= 1'b0;
					end
					if (ol_hit) begin
						ol_flag_r[g] <= 1'b1;
					end else if (lnk.clr_ol[g]) begin
						ol_flag_r[g] <= 1'b0;
					end
				end
			end
			// over-current lockout and timed recovery
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					oc_off_r <= 1'b0;
					rec_cnt_r <= '0;
				end else if (wipe) begin
					oc_off_r <= 1'b0;
					rec_cnt_r <= '0;
				end else if (oc_hit) begin
					oc_off_r <= 1'b1;
					rec_cnt_r <= '0;
				end else if (oc_off_r && lnk.oc_recov[g]) begin
					if (rec_cnt_r == CNT_W'(P_REC_CYC - 1)) begin
						oc_off_r <= 1'b0;
					end else begin
						rec_cnt_r <= rec_cnt_r + 1'b1;
					end
				end else if (oc_off_r && !oc_flag_r[g]) begin
					oc_off_r <= 1'b0;
				end
			end
			// pwm minimum off time, so the slope is not re-triggered
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					mo_cnt_r <= '0;
				end else if (lnk.pwm_en[g] && hs_r[g] && !hs_nxt[g]) begin
					mo_cnt_r <= CNT_W'(P_MINOFF_CYC);
				end else if (mo_cnt_r != '0) begin
					mo_cnt_r <= mo_cnt_r - 1'b1;
				end
			end
			if (g < NHB) begin : g_hb
				logic [CNT_W-1:0] xc_cnt_r;
				logic ls_want;
				logic hs_go;
				logic ls_go;
				logic ls_nxt;
				logic fo_r;
				assign ls_want = lnk.ls_ctrl[g] & !oc_off_r & !block_all;
				assign hs_go = want && !ls_r[g] && xc_cnt_r == '0;
				assign ls_go = ls_want && !hs_r[g] && xc_cnt_r == '0
					&& !hs_go;
				assign hs_nxt[g] = want & (hs_r[g] | hs_go);
				assign ls_nxt = ls_want & (ls_r[g] | ls_go);
				// dead time: any switch-off delays the opposite side
				always_ff @(posedge clk_in or posedge sys_rst_in) begin
					if (sys_rst_in) begin
						ls_r[g] <= 1'b0;
						xc_cnt_r <= '0;
						fo_r <= 1'b0;
					end else begin
						ls_r[g] <= ls_nxt;
						fo_r <= (xc_cnt_r == CNT_W'(1));
						if ((hs_r[g] && !hs_nxt[g]) || (ls_r[g] && !ls_nxt)) begin
							xc_cnt_r <= CNT_W'(XC_CYC);
						end else if (xc_cnt_r != '0) begin
							xc_cnt_r <= xc_cnt_r - 1'b1;
						end
					end
				end
				assign fast_off_out[g] = fo_r;
			end else begin : g_hs
				assign hs_nxt[g] = want;
			end
		end
	endgenerate

	// driver state, tristate and status registers toward the link
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hs_r <= '0;
			hiz_r <= 1'b1;
			ec_hiz_r <= 1'b1;
			awake_r <= 1'b0;
		end else begin
			hs_r <= hs_nxt;
			hiz_r <= block_all | wipe;
			ec_hiz_r <= !run | sup_block | wipe;
			awake_r <= (state_r != ST_STBY) && !wipe;
		end
	end

	// monitor routing and blanking after the selected driver turns on
	assign cm_idx = lnk.cm_sel - 1'b1;
	assign cm_on = lnk.cm_sel != CM_NONE
		&& lnk.cm_sel <= SEL_W'(NOUT) && hs_r[cm_idx];
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cm_prev_r <= CM_NONE;
			blank_cnt_r <= '0;
			cm_valid_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end else begin
			cm_prev_r <= lnk.cm_sel;
			pin_oe_n_r <= (lnk.cm_sel == CM_NONE) | !run;
			if (!cm_on || cm_prev_r != lnk.cm_sel) begin
				blank_cnt_r <= '0;
				cm_valid_r <= 1'b0;
			end else if (blank_cnt_r == CNT_W'(BLANK_CYC - 1)) begin
				cm_valid_r <= 1'b1;
			end else begin
				blank_cnt_r <= blank_cnt_r + 1'b1;
			end
		end
	end

	assign power_output_n_out = hs_r;
	assign ls_drv_out = ls_r;
	assign outputs_hiz_out = hiz_r;
	assign ec_hiz_out = ec_hiz_r;
	assign current_monitor_out = cm_valid_r;
	assign shared_monitor_pwm_pin_out = cm_valid_r;
	assign shared_monitor_pwm_pin_oe_n_out = pin_oe_n_r;
	assign lnk.oc_flag = oc_flag_r;
	assign lnk.ol_flag = ol_flag_r;
	assign lnk.glb_flag = g_flag_r;
	assign lnk.dev_awake = awake_r;
endmodule

// >>> hdl/ddp_mcu_end.sv
// ddp_mcu_end: controller side; frames control updates and clears.
// assumes user requests are synchronous to clk_in.
`timescale 1ns/100ps
module ddp_mcu_end import ddp_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	ddp_link_if.mcu lnk,
	input wire logic user_apply_in,
	input wire logic user_hold_in,
	input wire logic [NOUT-1:0] user_hs_in,
	input wire logic [NHB-1:0] user_ls_in,
	input wire logic [NOUT-1:0] user_pwm_en_in,
	input wire logic [NOUT-1:0] user_oc_recov_in,
	input wire logic user_sup_recov_dis_in,
	input wire logic [SEL_W-1:0] user_cm_sel_in,
	input wire logic [NOUT-1:0] user_clr_oc_in,
	input wire logic [NOUT-1:0] user_clr_ol_in,
	input wire logic user_clr_sup_in,
	input wire logic user_clr_temp_in,
	output logic busy_out,
	output logic awake_out,
	output logic [NOUT-1:0] stat_oc_out,
	output logic [NOUT-1:0] stat_ol_out,
	output logic [3:0] stat_glb_out
);
	ddp_host_e st_r;
	logic [CNT_W-1:0] cnt_r;
	logic woke_r;
	logic csn_r;
	logic [NOUT-1:0] hs_p_r, pwm_p_r, rec_p_r, coc_p_r, col_p_r;
	logic [NHB-1:0] ls_p_r;
	logic [SEL_W-1:0] sel_p_r;
	logic hold_p_r, srd_p_r, csup_p_r, ctmp_p_r;
	logic push;
	logic [NOUT-1:0] hs_r, pwm_r, rec_r, coc_r, col_r;
	logic [NHB-1:0] ls_r;
	logic [SEL_W-1:0] sel_r;
	logic hold_r, srd_r, csup_r, ctmp_r;

	// a sleeping device needs the wake delay before the first transfer
	assign push = (st_r == HS_SEL) && (woke_r
		|| cnt_r == CNT_W'(WAKE_WAIT_CYC - 1));

	// frame sequencer: select low, wait, commit, select high gap
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r <= HS_IDLE;
			cnt_r <= '0;
			csn_r <= 1'b1;
			woke_r <= 1'b0;
		end else begin
			case (st_r)
				HS_IDLE: begin
					cnt_r <= '0;
					if (user_apply_in) begin
						st_r <= HS_SEL;
						csn_r <= 1'b0;
						woke_r <= lnk.dev_awake;
					end
				end
				HS_SEL: begin
					if (push) begin
						st_r <= HS_REL;
						csn_r <= 1'b1;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				HS_REL: begin
					if (cnt_r == CNT_W'(CSN_HI_CYC - 1)) begin
						st_r <= HS_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	// request captured at apply so user inputs may change afterwards
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{hs_p_r, pwm_p_r, rec_p_r, coc_p_r, col_p_r} <= '0;
			ls_p_r <= '0;
			sel_p_r <= CM_NONE;
			{hold_p_r, srd_p_r, csup_p_r, ctmp_p_r} <= '0;
		end else if (st_r == HS_IDLE && user_apply_in) begin
			hs_p_r <= user_hs_in;
			pwm_p_r <= user_pwm_en_in;
			rec_p_r <= user_oc_recov_in;
			coc_p_r <= user_clr_oc_in;
			col_p_r <= user_clr_ol_in;
			ls_p_r <= user_ls_in;
			sel_p_r <= user_cm_sel_in;
			hold_p_r <= user_hold_in;
			srd_p_r <= user_sup_recov_dis_in;
			csup_p_r <= user_clr_sup_in;
			ctmp_p_r <= user_clr_temp_in;
		end
	end

	// link registers; clears are one-cycle strobes at commit
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{hs_r, pwm_r, rec_r, coc_r, col_r} <= '0;
			ls_r <= '0;
			sel_r <= CM_NONE;
			{hold_r, srd_r, csup_r, ctmp_r} <= '0;
		end else begin
			coc_r <= push ? coc_p_r : '0;
			col_r <= push ? col_p_r : '0;
			csup_r <= push & csup_p_r;
			ctmp_r <= push & ctmp_p_r;
			if (push) begin
				hs_r <= hs_p_r;
				pwm_r <= pwm_p_r;
				rec_r <= rec_p_r;
				ls_r <= ls_p_r;
				sel_r <= sel_p_r;
				hold_r <= hold_p_r;
				srd_r <= srd_p_r;
			end
		end
	end

	// status mirror toward the user
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_out <= 1'b0;
			awake_out <= 1'b0;
			stat_oc_out <= '0;
			stat_ol_out <= '0;
			stat_glb_out <= '0;
		end else begin
			busy_out <= (st_r != HS_IDLE) || user_apply_in;
			awake_out <= lnk.dev_awake;
			stat_oc_out <= lnk.oc_flag;
			stat_ol_out <= lnk.ol_flag;
			stat_glb_out <= lnk.glb_flag;
		end
	end

	assign lnk.chip_select_low = csn_r;
	assign lnk.enable_hold = hold_r;
	assign lnk.hs_ctrl = hs_r;
	assign lnk.ls_ctrl = ls_r;
	assign lnk.pwm_en = pwm_r;
	assign lnk.oc_recov = rec_r;
	assign lnk.sup_recov_dis = srd_r;
	assign lnk.low_bat_guard = GUARD_RST;
	assign lnk.cm_sel = sel_r;
	assign lnk.clr_oc = coc_r;
	assign lnk.clr_ol = col_r;
	assign lnk.clr_sup = csup_r;
	assign lnk.clr_temp = ctmp_r;
endmodule

// >>> sim/ddp_link_monitor.sv
// ddp_link_monitor: timing and sticky-flag checks on the link signals.
// assumes one clock; sits beside the link interface, not bound.
`timescale 1ns/100ps
module ddp_link_monitor import ddp_pkg::*; #(
	parameter int P_WIN_CYC = WIN_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_select_low,
	input wire logic enable_hold,
	input wire logic low_bat_guard,
	input wire logic [NOUT-1:0] clr_oc,
	input wire logic [NOUT-1:0] clr_ol,
	input wire logic clr_temp,
	input wire logic [NOUT-1:0] oc_flag,
	input wire logic [NOUT-1:0] ol_flag,
	input wire logic [3:0] glb_flag,
	input wire logic dev_awake
);
	// two cycles of slack for the registered select path
	localparam int WAIT_MIN = WAKE_WAIT_CYC - 2;
	logic csn_q;
	logic woke_r;
	logic [8:0] lo_cnt;
	int aw_cnt;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// select-low length and unheld awake time
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			csn_q <= 1'b1;
			woke_r <= 1'b0;
			lo_cnt <= '0;
			aw_cnt <= 0;
		end else begin
			csn_q <= chip_select_low;
			if (!chip_select_low && csn_q) begin
				woke_r <= !dev_awake;
			end
			lo_cnt <= chip_select_low ? 9'h000 : lo_cnt + 9'h001;
			aw_cnt <= (dev_awake && !enable_hold) ? aw_cnt + 1 : 0;
		end
	end
	property p_stby;
		!dev_awake && chip_select_low |=> !dev_awake;
	endproperty
	a_stby: assert property (p_stby) else $error("woke unselected");
	property p_wait;
		$rose(chip_select_low) && woke_r |-> lo_cnt >= WAIT_MIN;
	endproperty
	a_wait: assert property (p_wait) else $error("early transfer");
	property p_win;
		aw_cnt <= P_WIN_CYC + 2;
	endproperty
	a_win: assert property (p_win) else $error("stayed awake");
	property p_oc_stick;
		dev_awake && $past(dev_awake) |-> (~oc_flag & $past(oc_flag)
			& ~($past(clr_oc) | $past(clr_oc, 2))) == '0;
	endproperty
	a_oc_stick: assert property (p_oc_stick) else $error("oc lost");
	property p_ol_stick;
		dev_awake && $past(dev_awake) |-> (~ol_flag & $past(ol_flag)
			& ~($past(clr_ol) | $past(clr_ol, 2))) == '0;
	endproperty
	a_ol_stick: assert property (p_ol_stick) else $error("ol lost");
	property p_temp_stick;
		dev_awake && $past(dev_awake) && $fell(|glb_flag[3:2])
			|-> $past(clr_temp) || $past(clr_temp, 2);
	endproperty
	a_temp_stick: assert property (p_temp_stick) else $error("temp");
	property p_clr_pulse;
		clr_oc != '0 |=> clr_oc == '0;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("long clr");
	property p_guard;
		low_bat_guard == 1'b1;
	endproperty
	a_guard: assert property (p_guard) else $error("guard low");
	c_wake: cover property ($rose(dev_awake));
	c_oc: cover property ($rose(|oc_flag));
	c_tsd: cover property ($rose(glb_flag[3]));
endmodule

// >>> sim/ddp_link_tb_top.sv
// ddp_link_tb_top: both ends joined by the link, driven from the user side.
// assumes shortened window, open-load, off-time and recovery counts.
`timescale 1ns/100ps
module ddp_link_tb_top import ddp_pkg::*; ;
	localparam int W = 300; // must exceed the 200-cycle wake wait
	typedef struct {logic [1:0] k; logic [21:0] v; logic [21:0] m;} ddp_note_s;
	ddp_note_s q[$];
	ddp_note_s nt;
	int num_errors = 0;
	int comparisons = 0;
	logic [31:0] seed;
	logic clk_in, sys_rst_in, user_apply_in, user_hold_in, pwm_b;
	logic [NOUT-1:0] user_hs_in, user_pwm_en_in, user_oc_recov_in;
	logic [NOUT-1:0] user_clr_oc_in, user_clr_ol_in, oc_det_in, ul_det_in;
	logic [NHB-1:0] user_ls_in, ls_drv_out, fast_off_out;
	logic user_sup_recov_dis_in, user_clr_sup_in, user_clr_temp_in;
	logic [SEL_W-1:0] user_cm_sel_in;
	logic busy_out, awake_out, vcc_low_in, vs_ov_in, vs_uv_in;
	logic [NOUT-1:0] stat_oc_out, stat_ol_out, power_output_n_out;
	logic [3:0] stat_glb_out;
	logic temp_warning_in, thermal_shutdown_in, pwm_input_a_in;
	logic shared_monitor_pwm_pin_in, shared_monitor_pwm_pin_out;
	logic shared_monitor_pwm_pin_oe_n_out, current_monitor_out;
	logic outputs_hiz_out, ec_hiz_out;
	logic fo_q = 1'b0;
	logic [1:0] xc_seen = 2'b00;
	int gap = 0;
	// shared pin: device wins while its enable is low
	assign shared_monitor_pwm_pin_in = shared_monitor_pwm_pin_oe_n_out
		? pwm_b : shared_monitor_pwm_pin_out;
	ddp_link_if ddp_link_if_i ();
	ddp_mcu_end ddp_mcu_end_i (.clk_in, .sys_rst_in, .lnk(ddp_link_if_i),
		.user_apply_in, .user_hold_in, .user_hs_in, .user_ls_in,
		.user_pwm_en_in, .user_oc_recov_in, .user_sup_recov_dis_in,
		.user_cm_sel_in, .user_clr_oc_in, .user_clr_ol_in, .user_clr_sup_in,
		.user_clr_temp_in, .busy_out, .awake_out, .stat_oc_out, .stat_ol_out,
		.stat_glb_out);
	ddp_dev_end #(.P_WIN_CYC(W), .P_OL_CYC(60), .P_MINOFF_CYC(30),
		.P_REC_CYC(50)) ddp_dev_end_i (.clk_in, .sys_rst_in,
		.lnk(ddp_link_if_i), .vcc_low_in, .oc_det_in, .ul_det_in, .vs_ov_in,
		.vs_uv_in, .temp_warning_in, .thermal_shutdown_in, .pwm_input_a_in,
		.shared_monitor_pwm_pin_in, .shared_monitor_pwm_pin_out,
		.shared_monitor_pwm_pin_oe_n_out, .current_monitor_out,
		.power_output_n_out, .ls_drv_out, .fast_off_out, .outputs_hiz_out,
		.ec_hiz_out);
	ddp_link_monitor #(.P_WIN_CYC(W)) ddp_link_monitor_i (.clk_in,
		.sys_rst_in, .chip_select_low(ddp_link_if_i.chip_select_low),
		.enable_hold(ddp_link_if_i.enable_hold),
		.low_bat_guard(ddp_link_if_i.low_bat_guard),
		.clr_oc(ddp_link_if_i.clr_oc), .clr_ol(ddp_link_if_i.clr_ol),
		.clr_temp(ddp_link_if_i.clr_temp), .oc_flag(ddp_link_if_i.oc_flag),
		.ol_flag(ddp_link_if_i.ol_flag), .glb_flag(ddp_link_if_i.glb_flag),
		.dev_awake(ddp_link_if_i.dev_awake));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tally_and_finish();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task note(input logic [1:0] k, input logic [21:0] v, input logic [21:0] m);
		q.push_back('{k, v, m});
	endtask
	task cmp(input logic [21:0] a, input string s);
		comparisons++;
		if ((a & nt.m) !== (nt.v & nt.m)) begin
			num_errors++;
			$display("[FAIL] %0t %s exp %h got %h", $time, s, nt.v & nt.m,
				a & nt.m);
		end
	endtask
	task chk_drv();
		cmp({shared_monitor_pwm_pin_out, shared_monitor_pwm_pin_oe_n_out,
			ls_drv_out, current_monitor_out, ec_hiz_out, outputs_hiz_out,
			power_output_n_out}, "drv");
	endtask
	task chk_stat();
		cmp({stat_ol_out, stat_oc_out}, "stat");
	endtask
	task chk_glb();
		cmp({15'h0000, xc_seen, awake_out, stat_glb_out}, "glb");
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// one frame; oc, sup and temp clear strobes drop after capture (clr_ol is left as set), then wait for idle
	task apply(input int settle);
		int n;
		@(posedge clk_in) user_apply_in <= 1'b1;
		@(posedge clk_in) user_apply_in <= 1'b0;
		user_clr_oc_in <= '0;
		user_clr_sup_in <= 1'b0;
		user_clr_temp_in <= 1'b0;
		cyc(3);
		for (n = 0; n < 2000 && busy_out === 1'b1; n++) @(posedge clk_in);
		if (busy_out !== 1'b0) num_errors++;
		cyc(settle);
	endtask
	// notes are judged half a cycle later, once outputs settle
	always @(negedge clk_in) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			case (nt.k)
				2'd0: chk_drv();
				2'd1: chk_stat();
				default: chk_glb();
			endcase
		end
	end
	// bridge 1 dead time: first low-side turn-on after its high side went
	// off must wait the cross time and follow a fast-off pulse
	always @(negedge clk_in) begin
		fo_q <= fast_off_out[0];
		gap <= power_output_n_out[0] ? 0 : gap + 1;
		if (ls_drv_out[0] && xc_seen == 2'b00) begin
			xc_seen <= {gap >= XC_CYC, fo_q};
		end
	end
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// whole sequence needs about 14k cycles; over five times that is a hang
	initial begin
		cyc(80000);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{sys_rst_in, user_apply_in, user_hold_in, pwm_b} = 4'h8;
		{user_hs_in, user_pwm_en_in, user_oc_recov_in} = '0;
		{user_clr_oc_in, user_clr_ol_in, oc_det_in, ul_det_in} = '0;
		{user_ls_in, user_sup_recov_dis_in, user_clr_sup_in} = '0;
		{user_clr_temp_in, user_cm_sel_in, vcc_low_in, vs_ov_in} = '0;
		{vs_uv_in, temp_warning_in, thermal_shutdown_in} = '0;
		pwm_input_a_in = 1'b0;
		seed = 32'h0AD9;
		cyc(5);
		sys_rst_in <= 1'b0;
		cyc(2);
		note(2'd2, 22'h0, 22'h1F);
		apply(W);
		note(2'd2, 22'h0, 22'h10);
		user_hold_in <= 1'b1;
		user_hs_in <= 11'h003;
		user_cm_sel_in <= 4'h1;
		apply(150);
		note(2'd0, 22'h0, 22'h3);
		cyc(200);
		note(2'd0, 22'h3, 22'h2003);
		note(2'd2, 22'h10, 22'h10);
		cyc(1300);
		note(2'd0, 22'h202003, 22'h302003);
		user_hs_in <= 11'h011;
		user_pwm_en_in <= 11'h011;
		user_cm_sel_in <= CM_NONE;
		apply(W + 20);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			pwm_input_a_in <= seed[0];
			pwm_b <= seed[1];
			cyc(40);
			note(2'd0, {17'h0, seed[1], 3'h0, seed[0]}, 22'h11);
		end
		pwm_input_a_in <= 1'b1;
		cyc(40);
		pwm_input_a_in <= 1'b0;
		cyc(2);
		pwm_input_a_in <= 1'b1;
		cyc(10);
		note(2'd0, 22'h0, 22'h1);
		cyc(40);
		note(2'd0, 22'h1, 22'h1);
		user_hs_in <= 11'h003;
		user_pwm_en_in <= '0;
		apply(W + 20);
		oc_det_in <= 11'h001;
		cyc(1099);
		oc_det_in <= '0;
		cyc(5);
		note(2'd1, 22'h0, 22'h1);
		oc_det_in <= 11'h001;
		cyc(1105);
		note(2'd1, 22'h1, 22'h1);
		note(2'd0, 22'h2, 22'h3);
		oc_det_in <= '0;
		cyc(100);
		note(2'd0, 22'h2, 22'h3);
		user_clr_oc_in <= 11'h001;
		apply(W + 20);
		note(2'd1, 22'h0, 22'h1);
		note(2'd0, 22'h3, 22'h3);
		user_oc_recov_in <= 11'h002;
		apply(W + 20);
		oc_det_in <= 11'h002;
		cyc(1103);
		oc_det_in <= '0;
		cyc(5);
		note(2'd0, 22'h1, 22'h3);
		cyc(80);
		note(2'd0, 22'h3, 22'h3);
		ul_det_in <= 11'h002;
		cyc(70);
		note(2'd1, 22'h1000, 22'h1000);
		note(2'd0, 22'h3, 22'h3);
		ul_det_in <= '0;
		temp_warning_in <= 1'b1;
		cyc(650);
		note(2'd2, 22'h14, 22'h1C);
		note(2'd0, 22'h3, 22'h3);
		thermal_shutdown_in <= 1'b1;
		cyc(650);
		note(2'd2, 22'h8, 22'h8);
		note(2'd0, 22'h0, 22'h3);
		user_clr_temp_in <= 1'b1;
		apply(W + 20);
		note(2'd2, 22'hC, 22'hC);
		temp_warning_in <= 1'b0;
		thermal_shutdown_in <= 1'b0;
		user_clr_temp_in <= 1'b1;
		apply(W + 20);
		note(2'd2, 22'h0, 22'hC);
		note(2'd0, 22'h3, 22'h3);
		vs_ov_in <= 1'b1;
		cyc(650);
		note(2'd0, 22'h1800, 22'h1800);
		vs_ov_in <= 1'b0;
		cyc(700);
		note(2'd0, 22'h3, 22'h1803);
		user_sup_recov_dis_in <= 1'b1;
		user_clr_sup_in <= 1'b1;
		apply(W + 20);
		note(2'd0, 22'h3, 22'h1803);
		vs_uv_in <= 1'b1;
		cyc(650);
		vs_uv_in <= 1'b0;
		cyc(700);
		note(2'd0, 22'h1800, 22'h1800);
		user_clr_sup_in <= 1'b1;
		apply(W + 20);
		note(2'd0, 22'h3, 22'h1803);
		user_hs_in <= 11'h002;
		user_ls_in <= 6'h01;
		apply(W + 20);
		note(2'd0, 22'h4002, 22'h4003);
		note(2'd2, 22'h70, 22'h70);
		vcc_low_in <= 1'b1;
		cyc(3);
		vcc_low_in <= 1'b0;
		cyc(3);
		note(2'd2, 22'h0, 22'h1F);
		note(2'd1, 22'h0, 22'h3FFFFF);
		note(2'd0, 22'h1800, 22'h1803);
		cyc(2);
		tally_and_finish();
	end
endmodule
